// ---- bench/serial_node.sv ----
// Remote serial node: drives frames into the receive pin, decodes the transmit pin
module serial_node #(
  parameter int BIT_CYCLES = 16
) (
  input wire logic ref_clk, // Bus clock
  input wire logic serial_tx_line, // Frames from the block
  output logic serial_rx_line // Frames to the block
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [7:0] last_char;
  logic [7:0] shift;
  int char_count;
  // Line rests high between frames
  initial begin
    serial_rx_line = 1'b1;
    last_char = 8'h00;
    char_count = 0;
  end
  // Send one frame LSB first; a low stop level makes a framing fault or break
  task automatic send(input logic [8:0] d, input int nbits, input logic stop_level);
    @(posedge ref_clk);
    serial_rx_line <= 1'b0;
    repeat (BIT_CYCLES) @(posedge ref_clk);
    for (int i = 0; i < nbits; i++) begin
      serial_rx_line <= d[i];
      repeat (BIT_CYCLES) @(posedge ref_clk);
    end
    serial_rx_line <= stop_level;
    repeat (BIT_CYCLES) @(posedge ref_clk);
    serial_rx_line <= 1'b1;
  endtask : send
  // Decode 8-bit frames at mid-bit; a frame without a high stop bit is dropped
  always begin
    @(negedge serial_tx_line);
    repeat (BIT_CYCLES / 2) @(posedge ref_clk);
    for (int i = 0; i < 8; i++) begin
      repeat (BIT_CYCLES) @(posedge ref_clk);
      shift[i] = serial_tx_line;
    end
    repeat (BIT_CYCLES) @(posedge ref_clk);
    if (serial_tx_line === 1'b1) begin
      last_char = shift;
      char_count++;
    end
  end
endmodule : serial_node

// ---- bench/tb_serial_rx_wakeup.sv ----
// Testbench of the serial port core: wakeup, idle timing, flag groups and transmit
`include "serial_defines.svh"
`define check_eq(what, exp, got) \
  begin \
    check_count++; \
    if ((got) !== (exp)) begin \
      n_mismatch++; \
      $display("[ERR] %s expected %h seen %h", what, exp, got); \
    end \
  end
module tb_serial_rx_wakeup;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int BC = 16;
  localparam logic [31:0] CLR = 32'h0000_03fc;
  logic ref_clk = 1'b0;
  logic sys_rst;
  logic [7:0] addr;
  logic [31:0] wdata;
  logic wr;
  logic rd;
  logic [31:0] rdata;
  logic serial_rx_line;
  logic serial_tx_line;
  logic irq;
  logic irq_tx;
  logic irq_rx;
  logic irq_err;
  int n_mismatch = 0;
  int check_count = 0;
  // 40 MHz bus clock
  always #12.5 ref_clk = ~ref_clk;
  serial_rx_wakeup #(.BIT_CYCLES(BC)) serial_rx_wakeup_inst (
    .ref_clk(ref_clk), .sys_rst(sys_rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .serial_rx_line(serial_rx_line), .serial_tx_line(serial_tx_line),
    .irq(irq), .irq_tx(irq_tx), .irq_rx(irq_rx), .irq_err(irq_err));
  serial_node #(.BIT_CYCLES(BC)) serial_node_inst (
    .ref_clk(ref_clk), .serial_tx_line(serial_tx_line), .serial_rx_line(serial_rx_line));
  // ----------------------------------------------------------------
  // Bus helpers
  // ----------------------------------------------------------------
  function automatic logic [31:0] bitv(input int p);
    return 32'h1 << p;
  endfunction : bitv
  task automatic wait_cyc(input int n);
    repeat (n) @(posedge ref_clk);
  endtask : wait_cyc
  task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge ref_clk);
    wr <= 1'b0;
  endtask : reg_wr
  // Read data stand only in the cycle after the strobe
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e,
    input string what);
    logic [31:0] v;
    @(posedge ref_clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge ref_clk);
    rd <= 1'b0;
    @(negedge ref_clk);
    v = rdata;
    `check_eq(what, e & m, v & m)
  endtask : rd_chk
  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_reset;
    rd_chk(`OFS_CTRL, 32'hffff_ffff, {24'h0, `CTRL_RST}, "ctrl reset");
    rd_chk(`OFS_MASK, 32'hffff_ffff, {22'h0, `MASK_RST}, "mask reset");
    rd_chk(`OFS_STAT, 32'hffff_fffd, 32'h0000_0001, "status reset");
    reg_wr(8'h10, 32'h0000_00ff);
    rd_chk(8'h10, 32'hffff_ffff, 32'h0, "unmapped read");
    rd_chk(`OFS_CTRL, 32'hffff_ffff, 32'h0, "ctrl after stray write");
    `check_eq("irq at reset", 4'h0, {irq, irq_tx, irq_rx, irq_err})
    $display("test reset done");
  endtask : t_reset
  task automatic t_rx_basic;
    reg_wr(`OFS_STAT, CLR);
    serial_node_inst.send(9'h05a, 8, 1'b1);
    wait_cyc(4);
    rd_chk(`OFS_STAT, bitv(`ST_RX_FULL), bitv(`ST_RX_FULL), "rx full polled");
    `check_eq("irq_rx masked", 1'b0, irq_rx)
    reg_wr(`OFS_MASK, bitv(`ST_RX_FULL));
    @(negedge ref_clk);
    `check_eq("irq_rx enabled", 2'b11, {irq_rx, irq})
    rd_chk(`OFS_DATA, 32'h1ff, 32'h05a, "rx data");
    `check_eq("irq_rx after data read", 1'b0, irq_rx)
    $display("test rx basic done");
  endtask : t_rx_basic
  // Idle wake, counting from the start bit, 8-bit character
  task automatic t_idle_sleep;
    reg_wr(`OFS_STAT, CLR);
    reg_wr(`OFS_MASK, 32'h0);
    reg_wr(`OFS_CTRL, bitv(`CTL_SLEEP));
    serial_node_inst.send(9'h0ff, 8, 1'b1);
    wait_cyc(6);
    rd_chk(`OFS_CTRL, bitv(`CTL_SLEEP), bitv(`CTL_SLEEP), "asleep before idle");
    rd_chk(`OFS_STAT, bitv(`ST_RX_FULL), 32'h0, "char dropped asleep");
    wait_cyc(14);
    rd_chk(`OFS_CTRL, bitv(`CTL_SLEEP), 32'h0, "awake after idle");
    rd_chk(`OFS_STAT, bitv(`ST_IDLE), 32'h0, "idle flag silent");
    serial_node_inst.send(9'h033, 8, 1'b1);
    wait_cyc(4);
    rd_chk(`OFS_STAT, bitv(`ST_RX_FULL), bitv(`ST_RX_FULL), "first char after wake");
    rd_chk(`OFS_DATA, 32'h1ff, 32'h033, "first char data");
    $display("test idle sleep done");
  endtask : t_idle_sleep
  // Nine-bit idle length, idle flag raised while asleep
  task automatic t_idle_nine;
    reg_wr(`OFS_STAT, CLR);
    reg_wr(`OFS_CTRL, bitv(`CTL_NINE_BIT) | bitv(`CTL_SLEEP) | bitv(`CTL_IDLE_IN_SLEEP));
    serial_node_inst.send(9'h1ff, 9, 1'b1);
    wait_cyc(6);
    rd_chk(`OFS_STAT, bitv(`ST_IDLE), 32'h0, "no idle before 11 bits");
    wait_cyc(14);
    rd_chk(`OFS_STAT, bitv(`ST_IDLE), bitv(`ST_IDLE), "idle flag while asleep");
    rd_chk(`OFS_CTRL, bitv(`CTL_SLEEP), 32'h0, "nine-bit idle wakes");
    $display("test idle nine done");
  endtask : t_idle_nine
  // Idle counting from the end of the stop bit
  task automatic t_stop_count;
    reg_wr(`OFS_STAT, CLR);
    reg_wr(`OFS_CTRL, bitv(`CTL_CNT_START));
    serial_node_inst.send(9'h000, 8, 1'b1);
    wait_cyc(148);
    rd_chk(`OFS_STAT, bitv(`ST_IDLE), 32'h0, "no idle before stop-based count");
    wait_cyc(18);
    rd_chk(`OFS_STAT, bitv(`ST_IDLE), bitv(`ST_IDLE), "idle after stop-based count");
    $display("test idle after stop done");
  endtask : t_stop_count
  task automatic t_mark;
    reg_wr(`OFS_STAT, CLR);
    reg_wr(`OFS_CTRL, bitv(`CTL_WAKE) | bitv(`CTL_SLEEP));
    serial_node_inst.send(9'h012, 8, 1'b1);
    wait_cyc(4);
    rd_chk(`OFS_CTRL, bitv(`CTL_SLEEP), bitv(`CTL_SLEEP), "no mark stays asleep");
    rd_chk(`OFS_STAT, bitv(`ST_RX_FULL), 32'h0, "unmarked char dropped");
    fork
      serial_node_inst.send(9'h085, 8, 1'b1);
      begin
        wait_cyc(110);
        rd_chk(`OFS_CTRL, bitv(`CTL_SLEEP), bitv(`CTL_SLEEP), "asleep before top bit");
        wait_cyc(38);
        rd_chk(`OFS_CTRL, bitv(`CTL_SLEEP), 32'h0, "awake within stop bit");
      end
    join
    wait_cyc(4);
    rd_chk(`OFS_STAT, bitv(`ST_RX_FULL), bitv(`ST_RX_FULL), "address char flagged");
    rd_chk(`OFS_DATA, 32'h1ff, 32'h085, "address char data");
    $display("test address mark done");
  endtask : t_mark
  task automatic t_tx;
    int n0;
    int k;
    reg_wr(`OFS_MASK, bitv(`ST_TX_DONE));
    n0 = serial_node_inst.char_count;
    reg_wr(`OFS_DATA, 32'h0000_00a5);
    wait_cyc(40);
    @(negedge ref_clk);
    `check_eq("tx complete irq mid frame", 1'b0, irq_tx)
    rd_chk(`OFS_STAT, 32'h3, 32'h1, "tx flags mid frame");
    for (k = 0; k < 400 && serial_node_inst.char_count == n0; k++) wait_cyc(1);
    wait_cyc(BC);
    @(negedge ref_clk);
    `check_eq("tx char on wire", 8'ha5, serial_node_inst.last_char)
    `check_eq("tx line at rest", 2'b11, {serial_tx_line, irq_tx})
    reg_wr(`OFS_MASK, bitv(`ST_TX_EMPTY));
    @(negedge ref_clk);
    `check_eq("tx empty irq", 2'b11, {irq_tx, irq})
    reg_wr(`OFS_MASK, 32'h0);
    @(negedge ref_clk);
    `check_eq("tx irq masked", 1'b0, irq_tx)
    rd_chk(`OFS_STAT, 32'h3, 32'h3, "tx flags polled");
    $display("test transmit done");
  endtask : t_tx
  task automatic t_errors;
    reg_wr(`OFS_STAT, CLR);
    reg_wr(`OFS_CTRL, 32'h0);
    reg_wr(`OFS_MASK, bitv(`ST_FRAMING));
    serial_node_inst.send(9'h000, 8, 1'b0);
    wait_cyc(4);
    rd_chk(`OFS_STAT, 32'h130, 32'h130, "break framing edge");
    `check_eq("error group only", 3'b100, {irq_err, irq_rx, irq_tx})
    reg_wr(`OFS_MASK, bitv(`ST_BREAK));
    @(negedge ref_clk);
    `check_eq("receive group only", 3'b010, {irq_err, irq_rx, irq_tx})
    reg_wr(`OFS_STAT, CLR);
    reg_wr(`OFS_MASK, bitv(`ST_OVERRUN));
    serial_node_inst.send(9'h011, 8, 1'b1);
    serial_node_inst.send(9'h022, 8, 1'b1);
    wait_cyc(4);
    `check_eq("overrun irq", 2'b11, {irq_err, irq})
    rd_chk(`OFS_DATA, 32'h1ff, 32'h011, "data kept on overrun");
    reg_wr(`OFS_STAT, CLR);
    reg_wr(`OFS_CTRL, bitv(`CTL_PAR_EN));
    serial_node_inst.send(9'h001, 8, 1'b1);
    wait_cyc(4);
    rd_chk(`OFS_STAT, 32'h380, 32'h200, "parity fault only");
    $display("test error flags done");
  endtask : t_errors
  // ----------------------------------------------------------------
  // Run control
  // ----------------------------------------------------------------
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : end_of_test
  // Reset for 20 cycles, then the scenarios in turn
  initial begin
    sys_rst = 1'b1;
    addr = 8'h00;
    wdata = 32'h0;
    wr = 1'b0;
    rd = 1'b0;
    repeat (20) @(posedge ref_clk);
    sys_rst <= 1'b0;
    t_reset();
    t_rx_basic();
    t_idle_sleep();
    t_idle_nine();
    t_stop_count();
    t_mark();
    t_tx();
    t_errors();
    end_of_test();
  end
  // Cut a hang short well beyond the few thousand cycles the scenarios need
  initial begin
    #(60000 * 25);
    n_mismatch++;
    $display("[ERR] watchdog expired");
    end_of_test();
  end
endmodule : tb_serial_rx_wakeup

// ---- core/rx_evt_if.sv ----
// Events passed from the receive frame engine to the port core
interface rx_evt_if;
  logic fall;
  logic start_end;
  logic msb_seen;
  logic msb_val;
  logic char_done;
  logic frame_err;
  logic noise_err;
  logic parity_err;
  logic brk;
  logic [8:0] data;
  modport engine (output fall, start_end, msb_seen, msb_val, char_done, frame_err,
    noise_err, parity_err, brk, data);
  modport core (input fall, start_end, msb_seen, msb_val, char_done, frame_err,
    noise_err, parity_err, brk, data);
endinterface : rx_evt_if

// ---- core/rx_frame.sv ----
// Receive frame engine: start, data and stop bit timing with three-point sampling
`include "serial_defines.svh"
module rx_frame #(
  parameter int BIT_CYCLES = 16
) (
  input logic ref_clk, // Bus clock
  input logic sys_rst, // Synchronous reset
  input logic rx_line, // Receive pin
  input logic nine_bit, // Nine data bits
  input logic parity_en, // Top bit is parity
  input logic parity_odd, // Odd parity
  rx_evt_if.engine ev // Events to the core
);
  localparam logic [15:0] LAST_CYC = 16'(BIT_CYCLES - 1);
  localparam logic [15:0] MID_CYC = 16'(BIT_CYCLES / 2);
  serial_pkg::rx_state_t state;
  logic [15:0] cyc;
  logic [3:0] idx;
  logic [8:0] shreg;
  logic [2:0] smp;
  logic rx_prev;
  logic noisy;

  // Bit timing and majority decode
  wire bit_end = cyc == LAST_CYC;
  wire in_win = (cyc >= MID_CYC - 16'h0001) && (cyc <= MID_CYC + 16'h0001);
  wire maj = (smp[0] & smp[1]) | (smp[0] & smp[2]) | (smp[1] & smp[2]);
  wire split = (smp != 3'h0) && (smp != 3'h7);
  wire [3:0] last_idx = nine_bit ? `LAST_IDX9 : `LAST_IDX8;
  wire [8:0] frame_bits = nine_bit ? shreg : {1'b0, shreg[7:0]};

  // Events, qualified by the cycle in which they pulse
  assign ev.fall = rx_prev & ~rx_line;
  assign ev.start_end = (state == serial_pkg::RX_START) && bit_end && !maj;
  assign ev.msb_seen = (state == serial_pkg::RX_DATA) && bit_end && (idx == last_idx);
  assign ev.msb_val = maj;
  assign ev.char_done = (state == serial_pkg::RX_STOP) && bit_end;
  assign ev.frame_err = !maj;
  assign ev.noise_err = noisy | split;
  assign ev.parity_err = parity_en & ((^frame_bits) ^ parity_odd);
  assign ev.brk = (frame_bits == 9'h000) && !maj;
  assign ev.data = frame_bits;

  // Samples around mid bit and previous line level
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      smp <= 3'h7;
      rx_prev <= `LINE_IDLE;
    end else begin
      rx_prev <= rx_line;
      if (in_win) begin
        smp <= {smp[1:0], rx_line};
      end
    end
  end

  // Frame sequencer
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      state <= serial_pkg::RX_IDLE;
      cyc <= 16'h0000;
      idx <= 4'h0;
      shreg <= `RXD_RST;
      noisy <= 1'b0;
    end else begin
      cyc <= (bit_end || state == serial_pkg::RX_IDLE) ? 16'h0000 : cyc + 16'h0001;
      unique case (state)
        serial_pkg::RX_IDLE: begin
          if (!rx_line) begin
            state <= serial_pkg::RX_START;
            noisy <= 1'b0;
          end
        end
        serial_pkg::RX_START: begin
          if (bit_end) begin
            state <= maj ? serial_pkg::RX_IDLE : serial_pkg::RX_DATA;
            idx <= 4'h0;
            noisy <= split;
          end
        end
        serial_pkg::RX_DATA: begin
          if (bit_end) begin
            shreg[idx] <= maj;
            noisy <= noisy | split;
            if (idx == last_idx) begin
              state <= serial_pkg::RX_STOP;
            end else begin
              idx <= idx + 4'h1;
            end
          end
        end
        serial_pkg::RX_STOP: begin
          if (bit_end) begin
            state <= serial_pkg::RX_IDLE;
          end
        end
      endcase
    end
  end
endmodule : rx_frame

// ---- core/serial_defines.svh ----
// Register offsets, field positions, reset values and frame counts of the serial port
`ifndef SERIAL_DEFINES_SVH
`define SERIAL_DEFINES_SVH
// Register byte offsets
`define OFS_CTRL 8'h00
`define OFS_STAT 8'h04
`define OFS_MASK 8'h08
`define OFS_DATA 8'h0c
// Control register fields
`define CTL_WAKE 0
`define CTL_CNT_START 1
`define CTL_IDLE_IN_SLEEP 2
`define CTL_NINE_BIT 3
`define CTL_SLEEP 4
`define CTL_PAR_EN 5
`define CTL_PAR_ODD 6
// Flag positions, shared by status and mask registers
`define ST_TX_EMPTY 0
`define ST_TX_DONE 1
`define ST_RX_FULL 2
`define ST_IDLE 3
`define ST_RX_EDGE 4
`define ST_BREAK 5
`define ST_OVERRUN 6
`define ST_NOISE 7
`define ST_FRAMING 8
`define ST_PARITY 9
// Reset values
`define CTRL_RST 8'h00
`define MASK_RST 10'h000
`define RXD_RST 9'h000
// Idle character length in bit times, start and stop included
`define CHAR_BT8 5'h0a
`define CHAR_BT9 5'h0b
// Index of the most significant data bit
`define LAST_IDX8 4'h7
`define LAST_IDX9 4'h8
// Level of an inactive line
`define LINE_IDLE 1'b1
`endif

// ---- core/serial_pkg.sv ----
// State types of the serial receiver and transmitter
package serial_pkg;
  typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA, RX_STOP} rx_state_t;
  typedef enum logic [1:0] {TX_IDLE, TX_START, TX_DATA, TX_STOP} tx_state_t;
endpackage : serial_pkg

// ---- core/serial_rx_wakeup.sv ----
// Serial port core: receiver wakeup, transmitter, flags, masks and interrupt groups
//
// What this block does
// - A sleeping receiver clears its sleep bit by itself at a message boundary.
// - With wakeup method 0 the sleep bit clears after one full idle character time.
// - An idle character lasts 10 bit times with 8 data bits and 11 with 9.
// - An idle that wakes a sleeper with idle-flag-in-sleep clear does not set the idle flag.
// - With idle-flag-in-sleep set every idle sets the idle flag, asleep or not.
// - With count start select 0 idle counting begins right after the start bit.
// - With count start select 1 idle counting begins only after the stop bit time.
// - With wakeup method 1 a one in the top data bit clears the sleep bit.
// - That address character wakes before its stop bit and is received in full.
// - Three interrupt requests: transmit, receive and error groups.
// - Ten separate enables gate only the requests; flags still set for polling.
// - The transmit-empty flag requests a transmit interrupt while set and enabled.
// - Transmit-complete sets only once all is sent and the line rests high.
`include "serial_defines.svh"
module serial_rx_wakeup #(
  parameter int BIT_CYCLES = 16
) (
  input logic ref_clk, // Bus clock, 40 MHz
  input logic sys_rst, // Synchronous reset
  input logic [7:0] addr, // Register byte address
  input logic [31:0] wdata, // Write data
  input logic wr, // Write strobe
  input logic rd, // Read strobe
  output logic [31:0] rdata, // Read data, cycle after rd
  input logic serial_rx_line, // Receive pin
  output logic serial_tx_line, // Transmit pin
  output logic irq, // Any unmasked flag
  output logic irq_tx, // Transmit group request
  output logic irq_rx, // Receive group request
  output logic irq_err // Error group request
);
  localparam logic [15:0] LAST_CYC = 16'(BIT_CYCLES - 1);
  localparam logic [15:0] IDLE_8 = 16'(`CHAR_BT8 * BIT_CYCLES);
  localparam logic [15:0] IDLE_9 = 16'(`CHAR_BT9 * BIT_CYCLES);

  // ----------------------------------------------------------------
  // Registers and decode
  // ----------------------------------------------------------------
  logic [7:0] ctrl;
  logic [9:0] mask;
  logic [9:2] sticky;
  logic [8:0] rx_data;
  logic [8:0] tx_buf;
  logic tx_full;
  rx_evt_if ev ();

  // Address decode
  wire sel_ctrl = addr == `OFS_CTRL;
  wire sel_stat = addr == `OFS_STAT;
  wire sel_mask = addr == `OFS_MASK;
  wire sel_data = addr == `OFS_DATA;
  wire wr_ctrl = wr & sel_ctrl;
  wire wr_stat = wr & sel_stat;
  wire rd_data = rd & sel_data;
  wire wr_data = wr & sel_data;

  // Control fields
  wire wake_sel = ctrl[`CTL_WAKE];
  wire cnt_start_sel = ctrl[`CTL_CNT_START];
  wire idle_in_sleep = ctrl[`CTL_IDLE_IN_SLEEP];
  wire nine_bit = ctrl[`CTL_NINE_BIT];
  wire receiver_sleep = ctrl[`CTL_SLEEP];

  // ----------------------------------------------------------------
  // Receive frame engine
  // ----------------------------------------------------------------
  rx_frame #(
    .BIT_CYCLES(BIT_CYCLES)
  ) rx_frame_inst (
    .ref_clk(ref_clk),
    .sys_rst(sys_rst),
    .rx_line(serial_rx_line),
    .nine_bit(nine_bit),
    .parity_en(ctrl[`CTL_PAR_EN]),
    .parity_odd(ctrl[`CTL_PAR_ODD]),
    .ev(ev)
  );

  // ----------------------------------------------------------------
  // Idle detection
  // ----------------------------------------------------------------
  logic idle_armed;
  logic [15:0] idle_cnt;
  wire [15:0] idle_len = nine_bit ? IDLE_9 : IDLE_8;
  wire idle_evt = idle_armed && serial_rx_line && (idle_cnt == idle_len - 16'h0001);

  // Arming point: after the start bit or after the stop bit
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      idle_armed <= 1'b0;
    end else if (idle_evt) begin
      idle_armed <= 1'b0;
    end else if (ev.start_end) begin
      idle_armed <= ~cnt_start_sel;
    end else if (ev.char_done && cnt_start_sel) begin
      idle_armed <= 1'b1;
    end
  end

  // Counts consecutive idle-level cycles while armed
  always_ff @(posedge ref_clk) begin
    if (sys_rst || !idle_armed || !serial_rx_line) begin
      idle_cnt <= 16'h0000;
    end else begin
      idle_cnt <= idle_cnt + 16'h0001;
    end
  end

  // ----------------------------------------------------------------
  // Wakeup and control register
  // ----------------------------------------------------------------
  wire wake_idle = idle_evt & ~wake_sel;
  wire wake_mark = ev.msb_seen & ev.msb_val & wake_sel;
  wire wake = receiver_sleep & (wake_idle | wake_mark);

  // Software write wins over a wakeup in the same cycle
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      ctrl <= `CTRL_RST;
    end else if (wr_ctrl) begin
      ctrl <= wdata[7:0];
    end else if (wake) begin
      ctrl[`CTL_SLEEP] <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Flags and interrupt requests
  // ----------------------------------------------------------------
  wire rx_take = ev.char_done & ~receiver_sleep;
  wire rx_fresh = rx_take & ~sticky[`ST_RX_FULL];
  wire tx_idle;
  wire [9:0] flags;
  wire [9:0] set_v;
  wire [9:0] clr_v;
  wire [9:0] masked = flags & mask;

  // Event sources
  assign set_v[`ST_TX_EMPTY] = 1'b0;
  assign set_v[`ST_TX_DONE] = 1'b0;
  assign set_v[`ST_RX_FULL] = rx_take;
  assign set_v[`ST_IDLE] = idle_evt & (idle_in_sleep | ~receiver_sleep);
  assign set_v[`ST_RX_EDGE] = ev.fall;
  assign set_v[`ST_BREAK] = rx_take & ev.brk;
  assign set_v[`ST_OVERRUN] = rx_take & sticky[`ST_RX_FULL];
  assign set_v[`ST_NOISE] = rx_fresh & ev.noise_err;
  assign set_v[`ST_FRAMING] = rx_fresh & ev.frame_err;
  assign set_v[`ST_PARITY] = rx_fresh & ev.parity_err;

  // Write-one-to-clear; reading data also clears receive-full
  assign clr_v = (wr_stat ? wdata[9:0] : 10'h000) | (10'(rd_data) << `ST_RX_FULL);

  // Level flags of the transmitter, sticky flags of the receiver
  assign flags[`ST_TX_EMPTY] = ~tx_full;
  assign flags[`ST_TX_DONE] = ~tx_full & tx_idle;
  assign flags[9:2] = sticky;

  // Set wins over clear in the same cycle
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      sticky <= 8'h00;
    end else begin
      sticky <= (sticky & ~clr_v[9:2]) | set_v[9:2];
    end
  end

  // Group requests
  assign irq_tx = |masked[`ST_TX_DONE:`ST_TX_EMPTY];
  assign irq_rx = |masked[`ST_BREAK:`ST_RX_FULL];
  assign irq_err = |masked[`ST_PARITY:`ST_OVERRUN];
  assign irq = irq_tx | irq_rx | irq_err;

  // Mask register and received character
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      mask <= `MASK_RST;
      rx_data <= `RXD_RST;
    end else begin
      if (wr & sel_mask) begin
        mask <= wdata[9:0];
      end
      if (rx_fresh) begin
        rx_data <= ev.data;
      end
    end
  end

  // ----------------------------------------------------------------
  // Transmitter
  // ----------------------------------------------------------------
  serial_pkg::tx_state_t tx_state;
  logic [15:0] tx_cyc;
  logic [3:0] tx_idx;
  logic [8:0] tx_sh;
  wire tx_bit_end = tx_cyc == LAST_CYC;
  wire tx_take = (tx_state == serial_pkg::TX_IDLE) && tx_full;
  wire [3:0] tx_last = nine_bit ? `LAST_IDX9 : `LAST_IDX8;
  assign tx_idle = tx_state == serial_pkg::TX_IDLE;

  // Holding buffer, written only while empty
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      tx_full <= 1'b0;
      tx_buf <= `RXD_RST;
    end else if (wr_data && !tx_full) begin
      tx_full <= 1'b1;
      tx_buf <= wdata[8:0];
    end else if (tx_take) begin
      tx_full <= 1'b0;
    end
  end

  // Shifter: start bit, data least significant first, stop bit
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      tx_state <= serial_pkg::TX_IDLE;
      tx_cyc <= 16'h0000;
      tx_idx <= 4'h0;
      tx_sh <= `RXD_RST;
      serial_tx_line <= `LINE_IDLE;
    end else begin
      tx_cyc <= (tx_bit_end || tx_idle) ? 16'h0000 : tx_cyc + 16'h0001;
      unique case (tx_state)
        serial_pkg::TX_IDLE: begin
          if (tx_full) begin
            tx_sh <= tx_buf;
            tx_state <= serial_pkg::TX_START;
            serial_tx_line <= ~`LINE_IDLE;
          end
        end
        serial_pkg::TX_START: begin
          if (tx_bit_end) begin
            tx_state <= serial_pkg::TX_DATA;
            tx_idx <= 4'h0;
            serial_tx_line <= tx_sh[0];
            tx_sh <= tx_sh >> 1;
          end
        end
        serial_pkg::TX_DATA: begin
          if (tx_bit_end) begin
            if (tx_idx == tx_last) begin
              tx_state <= serial_pkg::TX_STOP;
              serial_tx_line <= `LINE_IDLE;
            end else begin
              tx_idx <= tx_idx + 4'h1;
              serial_tx_line <= tx_sh[0];
              tx_sh <= tx_sh >> 1;
            end
          end
        end
        serial_pkg::TX_STOP: begin
          if (tx_bit_end) begin
            tx_state <= serial_pkg::TX_IDLE;
          end
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Read port
  // ----------------------------------------------------------------
  wire [31:0] rd_mux = sel_ctrl ? {24'h000000, ctrl} :
                       sel_stat ? {22'h000000, flags} :
                       sel_mask ? {22'h000000, mask} :
                       sel_data ? {23'h000000, rx_data} : 32'h00000000;

  // Data valid only in the cycle after the strobe
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      rdata <= 32'h00000000;
    end else begin
      rdata <= rd ? rd_mux : 32'h00000000;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  logic [15:0] hi_run;
  logic [15:0] since_done;

  // Line-high run and time since the last stop bit end, saturating
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      hi_run <= 16'h0000;
      since_done <= 16'h0000;
    end else begin
      hi_run <= !serial_rx_line ? 16'h0000 : hi_run + 16'(hi_run != 16'hffff);
      since_done <= ev.char_done ? 16'h0000 : since_done + 16'(since_done != 16'hffff);
    end
  end

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (sys_rst);

  idle_wakes_a: assert property (idle_evt && !wake_sel && receiver_sleep && !wr_ctrl
    |=> !receiver_sleep) else $error("idle did not clear sleep");
  idle_length_a: assert property (idle_evt |-> hi_run >= idle_len - 16'h0001)
    else $error("idle detected before a full character time");
  idle_quiet_a: assert property (idle_evt && receiver_sleep && !idle_in_sleep
    && !sticky[`ST_IDLE] |=> !sticky[`ST_IDLE]) else $error("idle flag set by wakeup idle");
  idle_flag_a: assert property (idle_evt && idle_in_sleep |=> sticky[`ST_IDLE])
    else $error("idle flag missed");
  idle_late_a: assert property (idle_evt && cnt_start_sel |-> since_done >= idle_len - 16'h0002)
    else $error("idle count began before the stop bit ended");
  idle_early_a: assert property (ev.start_end && !cnt_start_sel |=> idle_armed)
    else $error("idle count not armed after start bit");
  mark_wake_a: assert property (wake_mark && receiver_sleep && !wr_ctrl
    |=> !receiver_sleep ##0 !ev.char_done) else $error("address mark did not wake");
  asleep_drop_a: assert property (ev.char_done && receiver_sleep && !sticky[`ST_RX_FULL]
    |=> !sticky[`ST_RX_FULL]) else $error("character accepted while asleep");
  awake_take_a: assert property (ev.char_done && !receiver_sleep
    |=> sticky[`ST_RX_FULL]) else $error("character not received");
  poll_flag_a: assert property (set_v[`ST_RX_FULL] && !mask[`ST_RX_FULL] && !(wr && sel_mask)
    |=> sticky[`ST_RX_FULL] && !masked[`ST_RX_FULL]) else $error("masked flag misbehaved");
  err_group_a: assert property ($rose(|masked[`ST_PARITY:`ST_OVERRUN])
    |-> irq_err && irq) else $error("error request missing");
  tx_empty_a: assert property (!tx_full && mask[`ST_TX_EMPTY] |-> irq_tx)
    else $error("transmit empty request missing");
  tx_done_a: assert property (flags[`ST_TX_DONE] |-> serial_tx_line
    && (irq_tx || !mask[`ST_TX_DONE])) else $error("complete with line active");

  cover_idle_wake: cover property (wake_idle && receiver_sleep);
  cover_mark_wake: cover property (wake_mark && receiver_sleep ##[1:300] rx_take);
  cover_overrun: cover property (set_v[`ST_OVERRUN]);
  cover_err_irq: cover property ($rose(irq_err));
endmodule : serial_rx_wakeup
